// ---- hdl/port_pin_map.svh ----
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH

// Register byte offsets on the bus
`define PIN_INPUT_OFFSET 4'h0
`define PIN_DIRECTION_OFFSET 4'h4
`define PIN_OUTPUT_OFFSET 4'h8
`define MCU_CONTROL_OFFSET 4'hc

// Reset values
`define PORT_REG_RESET 8'h00
`define MCU_CONTROL_RESET 8'h00

// Control register layout
`define MCU_CONTROL_WRITE_MASK 8'h93
`define JTAG_DISABLE_BIT 7
`define GLOBAL_PULLUP_DISABLE_BIT 4
`define VECTOR_TABLE_SELECT_BIT 1
`define VECTOR_CHANGE_ENABLE_BIT 0

`endif

// ---- hdl/port_pin_pkg.sv ----
package port_pin_pkg;

    // Sleep controller state
    typedef enum logic [2:0] {
        SLEEP_ACTIVE = 3'h0,
        SLEEP_IDLE = 3'h1,
        SLEEP_ADC_NOISE = 3'h2,
        SLEEP_POWER_DOWN = 3'h3,
        SLEEP_POWER_SAVE = 3'h4,
        SLEEP_STANDBY = 3'h5
    } sleep_mode_t;

    // External interrupt sense selection
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'h0,
        SENSE_ANY_CHANGE = 2'h1,
        SENSE_FALLING = 2'h2,
        SENSE_RISING = 2'h3
    } irq_sense_t;

endpackage

// ---- hdl/pin_cell.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pad side
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_n_o,
    output logic pullup_o,
    // Control from the port logic
    input wire logic input_enable_i,
    input wire logic pullup_next_i,
    input wire logic drive_next_i,
    input wire logic value_next_i,
    // Input taps
    output logic alt_func_input_o,
    output logic pin_level_o
);

    logic sync_first;
    logic sync_second;
    wire logic clamped_input;

    // Clamp to ground ahead of the input stage
    assign clamped_input = pad_i & input_enable_i;
    assign alt_func_input_o = clamped_input;
    assign pin_level_o = sync_second;

    // Two stage synchronizer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first <= clamped_input;
            sync_second <= sync_first;
        end
    end

    // Pad drive, tri-stated with pull-up off in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_o <= 1'b0;
            pad_oe_n_o <= 1'b1;
            pullup_o <= 1'b0;
        end else begin
            pad_o <= value_next_i;
            pad_oe_n_o <= ~drive_next_i;
            pullup_o <= pullup_next_i;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/ext_irq_edge.sv ----
`timescale 1ns/1ps
`default_nettype none

module ext_irq_edge #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Synchronized pin levels and sense setting
    input wire logic [PIN_COUNT-1:0] pin_level_i,
    input wire logic [2*PIN_COUNT-1:0] irq_sense_i,
    input wire logic [PIN_COUNT-1:0] flag_clear_i,
    // Sticky flags
    output logic [PIN_COUNT-1:0] irq_flag_o
);

    logic [2:0] settle;
    logic [PIN_COUNT-1:0] level_prev;
    wire logic primed;
    wire logic [PIN_COUNT-1:0] hit_bits;

    // Mask edges until the synchronizer holds the real pad level after reset
    assign primed = settle[2];

    // Set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle <= 3'h0;
            level_prev <= '0;
            irq_flag_o <= '0;
        end else begin
            settle <= {settle[1:0], 1'b1};
            level_prev <= pin_level_i;
            irq_flag_o <= (irq_flag_o & ~flag_clear_i) | hit_bits;
        end
    end

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pin
            wire logic rise;
            wire logic fall;
            wire logic hit;
            wire port_pin_pkg::irq_sense_t sense;
            assign sense = port_pin_pkg::irq_sense_t'(irq_sense_i[2*i+1:2*i]);
            assign rise = primed & pin_level_i[i] & ~level_prev[i];
            assign fall = primed & ~pin_level_i[i] & level_prev[i];
            // Clamp release on wake shows up here as an edge
            assign hit = (sense == port_pin_pkg::SENSE_RISING) ? rise :
                         (sense == port_pin_pkg::SENSE_FALLING) ? fall :
                         (sense == port_pin_pkg::SENSE_ANY_CHANGE) ? (rise | fall) :
                         1'b0;
            assign hit_bits[i] = hit;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- hdl/port_pin_override_logic.sv ----
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.svh"

module port_pin_override_logic #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sleep controller
    input wire port_pin_pkg::sleep_mode_t sleep_mode_i,
    // Peripheral overrides, one bit per pin
    input wire logic [PIN_COUNT-1:0] pullup_override_enable_i,
    input wire logic [PIN_COUNT-1:0] pullup_override_value_i,
    input wire logic [PIN_COUNT-1:0] direction_override_enable_i,
    input wire logic [PIN_COUNT-1:0] direction_override_value_i,
    input wire logic [PIN_COUNT-1:0] value_override_enable_i,
    input wire logic [PIN_COUNT-1:0] value_override_value_i,
    input wire logic [PIN_COUNT-1:0] toggle_override_enable_i,
    input wire logic [PIN_COUNT-1:0] input_enable_override_enable_i,
    input wire logic [PIN_COUNT-1:0] input_enable_override_value_i,
    // External interrupt control
    input wire logic [PIN_COUNT-1:0] irq_enable_i,
    input wire logic [2*PIN_COUNT-1:0] irq_sense_i,
    input wire logic [PIN_COUNT-1:0] irq_flag_clear_i,
    output logic [PIN_COUNT-1:0] irq_flag_o,
    // Pads
    input wire logic [PIN_COUNT-1:0] pad_i,
    output logic [PIN_COUNT-1:0] pad_o,
    output logic [PIN_COUNT-1:0] pad_oe_n_o,
    output logic [PIN_COUNT-1:0] pullup_o,
    // Taps for alternate functions
    output logic [PIN_COUNT-1:0] alt_func_input_o,
    output logic [PIN_COUNT-1:0] pad_analog_line_o,
    // Control register bits
    output logic jtag_interface_disable_o,
    output logic global_pullup_disable_o,
    output logic vector_table_select_o,
    output logic vector_change_enable_o
);

    logic [PIN_COUNT-1:0] pin_direction_bit;
    logic [PIN_COUNT-1:0] pin_output_bit;
    logic [7:0] mcu_control;
    logic ack;
    logic [31:0] read_data;

    wire logic [PIN_COUNT-1:0] pin_input_bit;
    wire logic [PIN_COUNT-1:0] next_pin_direction_bit;
    wire logic [PIN_COUNT-1:0] next_pin_output_bit;
    wire logic [7:0] next_mcu_control;
    wire logic [PIN_COUNT-1:0] write_bits;
    wire logic [7:0] write_byte;
    wire logic request;
    wire logic write_take;
    wire logic byte_lane;
    wire logic hit_input;
    wire logic hit_direction;
    wire logic hit_output;
    wire logic hit_control;
    wire logic [31:0] next_read_data;
    wire logic sleep_clamp;
    wire logic global_pullup_disable;

    // Bus handshake: ack one cycle after the request, write at the ack edge
    assign request = wb_cyc_i & wb_stb_i;
    assign write_take = request & wb_we_i & ack;
    assign byte_lane = wb_sel_i[0];
    assign write_byte = wb_dat_i[7:0];
    assign write_bits = write_byte[PIN_COUNT-1:0];

    // Address decode, shared by all pins of the port
    assign hit_input = (wb_adr_i == `PIN_INPUT_OFFSET);
    assign hit_direction = (wb_adr_i == `PIN_DIRECTION_OFFSET);
    assign hit_output = (wb_adr_i == `PIN_OUTPUT_OFFSET);
    assign hit_control = (wb_adr_i == `MCU_CONTROL_OFFSET);

    // Next register values
    assign next_pin_direction_bit = (write_take & byte_lane & hit_direction) ?
                                    write_bits : pin_direction_bit;
    assign next_pin_output_bit = (write_take & byte_lane & hit_output) ? write_bits :
                                 (write_take & byte_lane & hit_input) ?
                                 (pin_output_bit ^ write_bits) :
                                 pin_output_bit;
    assign next_mcu_control = (write_take & byte_lane & hit_control) ?
                              (write_byte & `MCU_CONTROL_WRITE_MASK) :
                              mcu_control;

    // Read mux; unmapped offsets read zero
    assign next_read_data = hit_input ? 32'(pin_input_bit) :
                            hit_direction ? 32'(pin_direction_bit) :
                            hit_output ? 32'(pin_output_bit) :
                            hit_control ? 32'(mcu_control) :
                            32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            read_data <= 32'h0000_0000;
        end else begin
            ack <= request & ~ack;
            read_data <= (request & ~ack) ? next_read_data : read_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_direction_bit <= PIN_COUNT'(`PORT_REG_RESET);
            pin_output_bit <= PIN_COUNT'(`PORT_REG_RESET);
            mcu_control <= `MCU_CONTROL_RESET;
        end else begin
            pin_direction_bit <= next_pin_direction_bit;
            pin_output_bit <= next_pin_output_bit;
            mcu_control <= next_mcu_control;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = read_data;
    assign jtag_interface_disable_o = mcu_control[`JTAG_DISABLE_BIT];
    assign global_pullup_disable_o = mcu_control[`GLOBAL_PULLUP_DISABLE_BIT];
    assign vector_table_select_o = mcu_control[`VECTOR_TABLE_SELECT_BIT];
    assign vector_change_enable_o = mcu_control[`VECTOR_CHANGE_ENABLE_BIT];

    // Shared by every pin of this port
    assign global_pullup_disable = mcu_control[`GLOBAL_PULLUP_DISABLE_BIT];
    assign sleep_clamp = (sleep_mode_i == port_pin_pkg::SLEEP_POWER_DOWN) |
                         (sleep_mode_i == port_pin_pkg::SLEEP_POWER_SAVE) |
                         (sleep_mode_i == port_pin_pkg::SLEEP_STANDBY);

    // Analog tap goes straight to the pad
    assign pad_analog_line_o = pad_i;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pin
            wire logic sleep_enable;
            wire logic input_enable;
            wire logic pullup_next;
            wire logic drive_next;
            wire logic data_bit;
            wire logic value_next;

            // Enabled external interrupt pins stay awake
            assign sleep_enable = ~sleep_clamp | irq_enable_i[i];
            assign input_enable = input_enable_override_enable_i[i] ?
                                  input_enable_override_value_i[i] :
                                  sleep_enable;
            assign pullup_next = pullup_override_enable_i[i] ?
                                 pullup_override_value_i[i] :
                                 (~pin_direction_bit[i] & pin_output_bit[i] &
                                  ~global_pullup_disable);
            assign drive_next = direction_override_enable_i[i] ?
                                direction_override_value_i[i] :
                                pin_direction_bit[i];
            assign data_bit = pin_output_bit[i] ^ toggle_override_enable_i[i];
            assign value_next = value_override_enable_i[i] ?
                                value_override_value_i[i] : data_bit;

            pin_cell u_pin_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pad_i(pad_i[i]),
                .pad_o(pad_o[i]),
                .pad_oe_n_o(pad_oe_n_o[i]),
                .pullup_o(pullup_o[i]),
                .input_enable_i(input_enable),
                .pullup_next_i(pullup_next),
                .drive_next_i(drive_next),
                .value_next_i(value_next),
                .alt_func_input_o(alt_func_input_o[i]),
                .pin_level_o(pin_input_bit[i])
            );
        end
    endgenerate

    // Flags watch the clamped, synchronized level
    ext_irq_edge #(
        .PIN_COUNT(PIN_COUNT)
    ) u_ext_irq_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_level_i(pin_input_bit),
        .irq_sense_i(irq_sense_i),
        .flag_clear_i(irq_flag_clear_i),
        .irq_flag_o(irq_flag_o)
    );

endmodule

`default_nettype wire

// ---- verification/port_pin_override_logic_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.svh"
module port_pin_override_logic_checker #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pin control
    input wire port_pin_pkg::sleep_mode_t sleep_mode_i,
    input wire logic [PIN_COUNT-1:0] pullup_override_enable_i,
    input wire logic [PIN_COUNT-1:0] pullup_override_value_i,
    input wire logic [PIN_COUNT-1:0] direction_override_enable_i,
    input wire logic [PIN_COUNT-1:0] direction_override_value_i,
    input wire logic [PIN_COUNT-1:0] value_override_enable_i,
    input wire logic [PIN_COUNT-1:0] value_override_value_i,
    input wire logic [PIN_COUNT-1:0] input_enable_override_enable_i,
    input wire logic [PIN_COUNT-1:0] input_enable_override_value_i,
    input wire logic [PIN_COUNT-1:0] irq_enable_i,
    // Pads and taps
    input wire logic [PIN_COUNT-1:0] pad_i,
    input wire logic [PIN_COUNT-1:0] pad_o,
    input wire logic [PIN_COUNT-1:0] pad_oe_n_o,
    input wire logic [PIN_COUNT-1:0] pullup_o,
    input wire logic [PIN_COUNT-1:0] alt_func_input_o,
    input wire logic [PIN_COUNT-1:0] pad_analog_line_o,
    input wire logic global_pullup_disable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_ctrl_read;
        wb_ack_o && !wb_we_i && wb_adr_i == `MCU_CONTROL_OFFSET;
    endsequence
    a_ack_pulse: assert property (s_taken |=> s_answer)
        else $error("ack not a single pulse after request");
    a_reserved_zero: assert property (s_ctrl_read |-> (wb_dat_o & ~32'h00000093) == '0)
        else $error("reserved control bits read nonzero");
    a_pud_readback: assert property (s_ctrl_read |-> wb_dat_o[4] == global_pullup_disable_o)
        else $error("pull-up disable bit readback differs");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> pullup_o == '0 && &pad_oe_n_o)
        else $error("pull-up or driver on in reset");
    a_pullup_override: assert property (!$past(rst_i) |->
        ((pullup_o ^ $past(pullup_override_value_i)) & $past(pullup_override_enable_i)) == '0)
        else $error("pull-up ignores override");
    a_pud_all_off: assert property (!$past(rst_i) && $past(global_pullup_disable_o) |->
        (pullup_o & ~$past(pullup_override_enable_i)) == '0)
        else $error("pull-up on while disabled");
    a_drive_override: assert property (!$past(rst_i) |->
        ((~pad_oe_n_o ^ $past(direction_override_value_i))
        & $past(direction_override_enable_i)) == '0)
        else $error("driver ignores direction override");
    a_value_override: assert property (!$past(rst_i) |->
        ((pad_o ^ $past(value_override_value_i)) & $past(value_override_enable_i)) == '0)
        else $error("pad value ignores override");
    a_input_override: assert property (((alt_func_input_o ^ (pad_i & input_enable_override_value_i))
        & input_enable_override_enable_i) == '0)
        else $error("input enable ignores override");
    a_sleep_clamp: assert property (sleep_mode_i >= port_pin_pkg::SLEEP_POWER_DOWN |->
        (alt_func_input_o & ~input_enable_override_enable_i & ~irq_enable_i) == '0)
        else $error("input not clamped in deep sleep");
    a_analog_tap: assert property (pad_analog_line_o == pad_i)
        else $error("analog tap differs from pad");
endmodule
bind port_pin_override_logic port_pin_override_logic_checker #(.PIN_COUNT(PIN_COUNT))
    port_pin_override_logic_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleep_mode_i(sleep_mode_i), .pullup_override_enable_i(pullup_override_enable_i),
    .pullup_override_value_i(pullup_override_value_i),
    .direction_override_enable_i(direction_override_enable_i),
    .direction_override_value_i(direction_override_value_i),
    .value_override_enable_i(value_override_enable_i),
    .value_override_value_i(value_override_value_i),
    .input_enable_override_enable_i(input_enable_override_enable_i),
    .input_enable_override_value_i(input_enable_override_value_i),
    .irq_enable_i(irq_enable_i), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o),
    .pullup_o(pullup_o), .alt_func_input_o(alt_func_input_o),
    .pad_analog_line_o(pad_analog_line_o), .global_pullup_disable_o(global_pullup_disable_o));
`default_nettype wire

// ---- verification/periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Requested override pattern
    input wire logic [8:0][7:0] set_i,
    // Override enables and values
    output logic [8:0][7:0] ovr_o
);
    // Overrides come from a register inside the peripheral
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovr_o <= '0;
        end else begin
            ovr_o <= set_i;
        end
    end
endmodule
`default_nettype wire

// ---- verification/port_pin_override_logic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.svh"
`define CHECK_EQ(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
end
module port_pin_override_logic_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [7:0] wdat = 8'h00, pad = 8'h00, irq_en = 8'h00, clr = 8'h00;
    logic [15:0] sense = 16'h0000;
    logic [8:0][7:0] set = '0;
    port_pin_pkg::sleep_mode_t mode = port_pin_pkg::SLEEP_ACTIVE;
    logic [31:0] seed = 32'h000102fd, q;
    int fail_count = 0, checked = 0, cycles = 0;
    wire logic [8:0][7:0] ovr;
    wire logic [31:0] rdat;
    wire logic ack, gpd, jtag_interface_disable, vts, vce;
    wire logic [7:0] pad_o, oe_n, pull, alt, ana, flag;
    periph_model periph_model_i (.clk_i(clk_i), .rst_i(rst_i), .set_i(set), .ovr_o(ovr));
    port_pin_override_logic #(.PIN_COUNT(8)) port_pin_override_logic_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h000000, wdat}), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sleep_mode_i(mode),
        .pullup_override_enable_i(ovr[0]), .pullup_override_value_i(ovr[1]),
        .direction_override_enable_i(ovr[2]), .direction_override_value_i(ovr[3]),
        .value_override_enable_i(ovr[4]), .value_override_value_i(ovr[5]),
        .toggle_override_enable_i(ovr[6]), .input_enable_override_enable_i(ovr[7]),
        .input_enable_override_value_i(ovr[8]), .irq_enable_i(irq_en), .irq_sense_i(sense),
        .irq_flag_clear_i(clr), .irq_flag_o(flag), .pad_i(pad), .pad_o(pad_o),
        .pad_oe_n_o(oe_n), .pullup_o(pull), .alt_func_input_o(alt), .pad_analog_line_o(ana),
        .jtag_interface_disable_o(jtag_interface_disable), .global_pullup_disable_o(gpd),
        .vector_table_select_o(vts), .vector_change_enable_o(vce));
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_ie();
        logic [7:0] nat;
        nat = (mode >= port_pin_pkg::SLEEP_POWER_DOWN) ? irq_en : 8'hff;
        return (set[7] & set[8]) | (~set[7] & nat);
    endfunction
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        wb(1'b0, a, 8'h00);
        `CHECK_EQ(nm, {24'h000000, e}, q)
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] dir, out, tog, drv;
        logic [8:0][7:0] pick;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHECK_EQ("drive_off", 8'hff, oe_n)
        `CHECK_EQ("ctrl_bits_reset", 4'h0, {jtag_interface_disable, gpd, vts, vce})
        rd(`MCU_CONTROL_OFFSET, 8'h00, "ctrl_reset");
        wb(1'b1, `MCU_CONTROL_OFFSET, 8'hff);
        rd(`MCU_CONTROL_OFFSET, `MCU_CONTROL_WRITE_MASK, "ctrl_mask");
        `CHECK_EQ("pud_out", 1'b1, gpd)
        `CHECK_EQ("ctrl_bits", 4'hf, {jtag_interface_disable, gpd, vts, vce})
        rd(4'h2, 8'h00, "unmapped");
        $display("test registers done");
        for (int it = 0; it < 40; it++) begin
            dir = rnd();
            out = rnd();
            tog = rnd();
            for (int k = 0; k < 9; k++) begin
                pick[k] = rnd() & rnd();
            end
            if (it < 2) begin
                pick = '0;
                dir = 8'h00;
                out = 8'hff;
                tog = (it == 1) ? 8'hff : 8'h00;
            end
            set <= pick;
            pad <= rnd();
            irq_en <= rnd();
            mode <= port_pin_pkg::sleep_mode_t'(3'(rnd() % 6));
            wb(1'b1, `PIN_DIRECTION_OFFSET, dir);
            wb(1'b1, `PIN_OUTPUT_OFFSET, out);
            wb(1'b1, `MCU_CONTROL_OFFSET, {3'b000, tog[4], 4'h0});
            repeat (3) @(posedge clk_i);
            `CHECK_EQ("pullup", (set[0] & set[1]) | (~set[0] & ~dir & out & {8{~tog[4]}}), pull)
            drv = (set[2] & set[3]) | (~set[2] & dir);
            `CHECK_EQ("drive", drv, ~oe_n)
            `CHECK_EQ("value", ((set[4] & set[5]) | (~set[4] & (out ^ set[6]))) & drv, pad_o & drv)
            `CHECK_EQ("alt_input", pad & exp_ie(), alt)
            `CHECK_EQ("analog", pad, ana)
            rd(`PIN_INPUT_OFFSET, pad & exp_ie(), "pin_input");
            tog = rnd();
            wb(1'b1, `PIN_INPUT_OFFSET, tog);
            rd(`PIN_OUTPUT_OFFSET, out ^ tog, "toggle");
        end
        $display("test random done");
        set <= '0;
        sense <= 16'hffff;
        irq_en <= 8'h00;
        pad <= 8'ha5;
        mode <= port_pin_pkg::SLEEP_STANDBY;
        repeat (6) @(posedge clk_i);
        clr <= 8'hff;
        @(posedge clk_i);
        clr <= 8'h00;
        repeat (2) @(posedge clk_i);
        `CHECK_EQ("flag_clear", 8'h00, flag)
        mode <= port_pin_pkg::SLEEP_ACTIVE;
        repeat (5) @(posedge clk_i);
        `CHECK_EQ("wake_flag", 8'ha5, flag)
        $display("test wake done");
        wb(1'b1, `PIN_DIRECTION_OFFSET, 8'h00);
        wb(1'b1, `PIN_OUTPUT_OFFSET, 8'hff);
        wb(1'b1, `MCU_CONTROL_OFFSET, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHECK_EQ("pullup_on", 8'hff, pull)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHECK_EQ("pullup_reset", 8'h00, pull)
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHECK_EQ("flag_after_reset", 8'h00, flag)
        $display("test reset done");
        conclude();
    end
endmodule
`default_nettype wire
